/* File: rtl/uda_pkg.sv */
// package for the serial port data, baud and address-match block
// assumes a single system clock; offsets are byte addresses on the bus
package uda_pkg;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [4:0] OFS_RX_DATA = 5'h00; // receive_char_data
  localparam logic [4:0] OFS_TX_DATA = 5'h04; // transmit_char_data
  localparam logic [4:0] OFS_BAUD = 5'h08; // baud_divisor
  localparam logic [4:0] OFS_ADMD = 5'h0c; // address_match_config
  localparam logic [4:0] OFS_CTRL = 5'h10; // mode control
  localparam logic [4:0] OFS_STAT = 5'h14; // status

  // reset values
  localparam logic [15:0] RST_RX_DATA = 16'h0000;
  localparam logic [15:0] RST_BAUD = 16'h0000;
  localparam logic [15:0] RST_ADMD = 16'h0000;
  localparam logic [15:0] RST_CTRL = 16'h0000;

  // field positions
  localparam int CHAR_W = 9; // character bits held in data registers
  localparam int ADMD_ADDR_LSB = 0; // match_address_value
  localparam int ADMD_MASK_LSB = 8; // match_bit_select
  localparam int CTRL_ENABLE_BIT = 0; // port enable
  localparam int CTRL_HIGH_SPEED_BIT = 1; // high_speed_bit_timing
  localparam int CTRL_FMT_LSB = 2; // char_format_select, two bits
  localparam int CTRL_ADDR_DET_BIT = 4; // address_detect_enable
  localparam int STAT_RXDA_BIT = 0; // receive_data_available
  localparam int STAT_OVERRUN_BIT = 1; // write one to clear
  localparam int STAT_FERR_BIT = 2; // framing error of head char
  localparam int STAT_PERR_BIT = 3; // parity error of head char
  localparam int STAT_TXFULL_BIT = 4; // transmit holding register full
  localparam int STAT_TX_IDLE_BIT = 5; // nothing queued or shifting
  localparam int STAT_RX_IDLE_BIT = 6; // receiver idle

  // character format codes
  localparam logic [1:0] FMT_8_NONE = 2'h0;
  localparam logic [1:0] FMT_8_EVEN = 2'h1;
  localparam logic [1:0] FMT_8_ODD = 2'h2;
  localparam logic [1:0] FMT_9_NONE = 2'h3;

  // baud generator ticks per serial bit
  localparam logic [4:0] TICKS_HIGH_SPEED = 5'h04;
  localparam logic [4:0] TICKS_STANDARD = 5'h10;

  // last data bit index for 8 and 9 bit characters
  localparam logic [3:0] LAST_IDX_8 = 4'h7;
  localparam logic [3:0] LAST_IDX_9 = 4'h8;

  // serial frame sequencing, shared by both directions
  typedef enum logic [2:0] {
    SER_IDLE,
    SER_START,
    SER_DATA,
    SER_PARITY,
    SER_STOP
  } uda_ser_state_t;

  // one received character with its error flags
  typedef struct packed {
    logic perr;
    logic ferr;
    logic [8:0] data;
  } uda_rx_char_t;

endpackage

/* File: rtl/uda_baud_gen.sv */
// baud tick generator: one tick every divisor+1 system clocks
// assumes divisor is stable while the port runs
`timescale 1ns/1ps
`default_nettype none
module uda_baud_gen
  import uda_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic run, // port enabled
  input wire logic [15:0] divisor, // baud_divisor_value
  output logic tick // one-cycle baud tick
);

  logic [15:0] cnt_r; // clocks since last tick
  logic tick_r; // registered tick
  wire wrap = (cnt_r >= divisor); // >= recovers from a divisor cut

  assign tick = tick_r;

  // count 0..divisor, pulse on wrap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
      tick_r <= wrap;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/uda_addr_match.sv */
// masked compare of a received character with the match address
// assumes the caller qualifies the result with the detect mode
`timescale 1ns/1ps
`default_nettype none
module uda_addr_match
  import uda_pkg::*;
(
  input wire logic [8:0] rx_char, // received character, bit 8 = address
  input wire logic [15:0] match_cfg, // address_match_config
  output logic hit // address char that matches
);

  wire [7:0] match_address_value = match_cfg[ADMD_ADDR_LSB +: 8];
  wire [7:0] match_bit_select = match_cfg[ADMD_MASK_LSB +: 8];
  wire [7:0] diff = rx_char[7:0] ^ match_address_value;
  wire is_addr = rx_char[8];

  // cleared select bits are don't-care
  assign hit = is_addr & ((diff & match_bit_select) == 8'h00);

endmodule
`default_nettype wire

/* File: rtl/uda_port.sv */
// serial port data, baud divisor and address-match registers with
// the transmit and receive engines they steer
// assumes an Avalon-MM master and a synchronous serial input
//
// Functional notes
// - receive data in low nine bits, rest zero
// - receive data read-only, resets to zero
// - transmit data takes nine-bit character
// - transmit data write-only, reads back zero
// - baud divisor sixteen bits, read/write, reset zero
// - low byte holds the match address
// - set mask bit includes that address bit
// - cleared mask bit is don't-care
// - hardware filters address characters itself
// - detect only in nine-bit format, bit8 set
// - bit lasts 4 or 16 baud ticks
// - format 11 nine bits, 01 and 10 eight with parity, 00 eight without
`timescale 1ns/1ps
`default_nettype none
module uda_port
  import uda_pkg::*;
#(
  parameter int RX_DEPTH = 4 // receive buffer entries, power of two
)(
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall, low on the accept cycle
  input wire logic serial_rx_in, // serial line in, idle high
  output logic serial_tx_out, // serial line out, idle high
  output logic addr_match_pulse // matching address char received
);

  localparam int PTR_W = $clog2(RX_DEPTH); // buffer pointer width

  // register state
  logic [15:0] baud_divisor_r; // baud_divisor
  logic [15:0] admd_r; // address_match_config
  logic [15:0] ctrl_r; // mode control
  logic [8:0] tx_hold_r; // transmit_char_data holding
  logic tx_full_r; // holding register occupied
  logic overrun_r; // receive overrun, sticky
  logic wait_r; // waitrequest flop
  logic [31:0] rdata_r; // read data flop
  logic pop_ok_r; // latched read may pop
  logic tx_out_r; // serial output flop
  logic match_r; // match pulse flop

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign serial_tx_out = tx_out_r;
  assign addr_match_pulse = match_r;

  // control decode
  wire port_on = ctrl_r[CTRL_ENABLE_BIT]; // port enable
  wire high_speed_bit_timing = ctrl_r[CTRL_HIGH_SPEED_BIT];
  wire [1:0] char_format_select = ctrl_r[CTRL_FMT_LSB +: 2];
  wire address_detect_enable = ctrl_r[CTRL_ADDR_DET_BIT];
  wire nine_bit = (char_format_select == FMT_9_NONE);
  wire has_parity = (char_format_select == FMT_8_EVEN) ||
      (char_format_select == FMT_8_ODD);
  wire odd_parity = (char_format_select == FMT_8_ODD);
  wire adet_on = address_detect_enable & nine_bit;
  wire [3:0] last_idx = nine_bit ? LAST_IDX_9 : LAST_IDX_8;
  wire [4:0] bit_ticks = high_speed_bit_timing ? TICKS_HIGH_SPEED
      : TICKS_STANDARD;
  wire [4:0] full_last = bit_ticks - 5'h01; // last tick of a bit
  wire [4:0] half_last = (bit_ticks >> 1) - 5'h01; // mid-bit point

  // baud generator
  logic tick; // baud tick
  uda_baud_gen u_baud (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(port_on),
    .divisor(baud_divisor_r),
    .tick(tick)
  );

  // bus decode
  wire req = avs_read | avs_write; // request present
  wire first = req & wait_r; // first cycle of request
  wire accept = req & ~wait_r; // request completes this edge
  wire wr_go = accept & avs_write; // write takes effect
  wire sel_rx = (avs_address == OFS_RX_DATA);
  wire sel_tx = (avs_address == OFS_TX_DATA);
  wire sel_baud = (avs_address == OFS_BAUD);
  wire sel_admd = (avs_address == OFS_ADMD);
  wire sel_ctrl = (avs_address == OFS_CTRL);
  wire sel_stat = (avs_address == OFS_STAT);

  // merge written byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) res[7:0] = wd[7:0];
    if (be[1]) res[15:8] = wd[15:8];
    return res;
  endfunction

  // receive buffer
  uda_rx_char_t mem_r [RX_DEPTH]; // buffered characters
  logic [PTR_W-1:0] wr_ptr_r; // next write slot
  logic [PTR_W-1:0] rd_ptr_r; // oldest character
  logic [PTR_W:0] count_r; // characters held
  uda_rx_char_t head; // oldest character
  uda_rx_char_t rx_char; // completed character
  logic rx_done; // frame finished this cycle
  logic store; // completed character to be kept

  assign head = mem_r[rd_ptr_r];
  wire rx_empty = (count_r == '0);
  wire rx_full = (count_r == (PTR_W+1)'(RX_DEPTH));
  wire push = rx_done & store & ~rx_full;
  wire pop = accept & avs_read & pop_ok_r;
  wire receive_data_available = ~rx_empty;

  // one entry per slot, written on push
  genvar gi;
  generate
    for (gi = 0; gi < RX_DEPTH; gi++) begin : g_slot
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          mem_r[gi] <= '0;
        end else if (push && wr_ptr_r == PTR_W'(gi)) begin
          mem_r[gi] <= rx_char;
        end
      end
    end
  endgenerate

  // pointers and count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  // read mux
  logic rx_idle; // receiver not in a frame
  logic tx_idle; // transmitter fully idle
  wire [15:0] stat_val = {9'h000,
    rx_idle, tx_idle, tx_full_r,
    head.perr, head.ferr, overrun_r,
    receive_data_available};
  logic [15:0] rd_val; // selected register value
  always_comb begin
    rd_val = 16'h0000; // unmapped and transmit data read zero
    if (sel_rx) rd_val = {7'h00, head.data};
    else if (sel_tx) rd_val = 16'h0000;
    else if (sel_baud) rd_val = baud_divisor_r;
    else if (sel_admd) rd_val = admd_r;
    else if (sel_ctrl) rd_val = ctrl_r;
    else if (sel_stat) rd_val = stat_val;
  end

  // bus handshake: one wait cycle, then accept
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      pop_ok_r <= 1'b0;
    end else begin
      wait_r <= ~first;
      if (first) begin
        rdata_r <= avs_read ? {16'h0000, rd_val} : 32'h0000_0000;
        pop_ok_r <= avs_read & sel_rx & ~rx_empty;
      end
    end
  end

  // software-written registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      baud_divisor_r <= RST_BAUD;
      admd_r <= RST_ADMD;
      ctrl_r <= RST_CTRL;
    end else if (wr_go) begin
      if (sel_baud) baud_divisor_r <= merge16(baud_divisor_r, avs_writedata,
        avs_byteenable);
      if (sel_admd) admd_r <= merge16(admd_r, avs_writedata, avs_byteenable);
      if (sel_ctrl) ctrl_r <= merge16(ctrl_r, avs_writedata, avs_byteenable);
    end
  end

  // overrun flag: set wins over write-one-to-clear
  wire ovr_set = rx_done & store & rx_full;
  wire ovr_clr = wr_go & sel_stat & avs_byteenable[0] &
                 avs_writedata[STAT_OVERRUN_BIT];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) overrun_r <= 1'b0;
    else if (ovr_set) overrun_r <= 1'b1;
    else if (ovr_clr) overrun_r <= 1'b0;
  end

  // transmitter
  uda_ser_state_t tx_st_r; // transmit frame state
  logic [4:0] tx_sub_r; // ticks into current bit
  logic [3:0] tx_idx_r; // data bit index
  logic [8:0] tx_shift_r; // bits being sent
  logic tx_par_r; // running parity of sent data
  wire tx_bit_end = tick & (tx_sub_r == full_last);
  wire tx_load = port_on & tx_full_r & (tx_st_r == SER_IDLE);
  wire tx_wr = wr_go & sel_tx & avs_byteenable[0] & ~tx_full_r;
  assign tx_idle = ~tx_full_r & (tx_st_r == SER_IDLE);

  // holding register, drained by the shifter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_r <= 9'h000;
      tx_full_r <= 1'b0;
    end else if (tx_wr) begin
      tx_hold_r <= avs_writedata[CHAR_W-1:0];
      tx_full_r <= 1'b1;
    end else if (tx_load || !port_on) begin
      tx_full_r <= 1'b0;
    end
  end

  // frame sequencer: start, data lsb first, parity, stop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r <= SER_IDLE;
      tx_sub_r <= 5'h00;
      tx_idx_r <= 4'h0;
      tx_shift_r <= 9'h000;
      tx_par_r <= 1'b0;
      tx_out_r <= 1'b1;
    end else if (!port_on) begin
      tx_st_r <= SER_IDLE;
      tx_out_r <= 1'b1;
    end else begin
      if (tick) tx_sub_r <= tx_bit_end ? 5'h00 : tx_sub_r + 5'h01;
      case (tx_st_r)
        SER_IDLE: begin
          tx_out_r <= 1'b1;
          tx_sub_r <= 5'h00;
          if (tx_load) begin
            tx_shift_r <= nine_bit ? tx_hold_r : {1'b0, tx_hold_r[7:0]};
            tx_par_r <= odd_parity;
            tx_idx_r <= 4'h0;
            tx_out_r <= 1'b0;
            tx_st_r <= SER_START;
          end
        end
        SER_START: begin
          if (tx_bit_end) begin
            tx_out_r <= tx_shift_r[0];
            tx_st_r <= SER_DATA;
          end
        end
        SER_DATA: begin
          if (tx_bit_end) begin
            tx_par_r <= tx_par_r ^ tx_shift_r[0];
            tx_shift_r <= {1'b0, tx_shift_r[8:1]};
            tx_idx_r <= tx_idx_r + 4'h1;
            if (tx_idx_r == last_idx) begin
              tx_out_r <= has_parity ? (tx_par_r ^ tx_shift_r[0]) : 1'b1;
              tx_st_r <= has_parity ? SER_PARITY : SER_STOP;
            end else begin
              tx_out_r <= tx_shift_r[1];
            end
          end
        end
        SER_PARITY: begin
          if (tx_bit_end) begin
            tx_out_r <= 1'b1;
            tx_st_r <= SER_STOP;
          end
        end
        SER_STOP: begin
          if (tx_bit_end) tx_st_r <= SER_IDLE;
        end
        default: tx_st_r <= SER_IDLE;
      endcase
    end
  end

  // receiver
  uda_ser_state_t rx_st_r; // receive frame state
  logic [4:0] rx_sub_r; // ticks into current bit
  logic [3:0] rx_idx_r; // data bit index
  logic [8:0] rx_shift_r; // bits gathered
  logic rx_par_r; // running parity
  logic rx_perr_r; // parity error of this frame
  logic hit; // masked address match
  wire [4:0] rx_target = (rx_st_r == SER_START) ? half_last : full_last;
  wire rx_sample = tick & (rx_sub_r == rx_target);
  assign rx_idle = (rx_st_r == SER_IDLE);
  assign rx_done = rx_sample & (rx_st_r == SER_STOP);
  assign rx_char = '{perr: rx_perr_r, ferr: ~serial_rx_in,
    data: rx_shift_r};

  uda_addr_match u_match (
    .rx_char(rx_shift_r),
    .match_cfg(admd_r),
    .hit(hit)
  );

  // detect mode keeps matching address chars
  assign store = ~adet_on | hit;

  // sample mid-bit after a half-bit start check
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= SER_IDLE;
      rx_sub_r <= 5'h00;
      rx_idx_r <= 4'h0;
      rx_shift_r <= 9'h000;
      rx_par_r <= 1'b0;
      rx_perr_r <= 1'b0;
    end else if (!port_on) begin
      rx_st_r <= SER_IDLE;
    end else begin
      if (tick) rx_sub_r <= rx_sample ? 5'h00 : rx_sub_r + 5'h01;
      case (rx_st_r)
        SER_IDLE: begin
          rx_sub_r <= 5'h00;
          if (!serial_rx_in) begin
            rx_idx_r <= 4'h0;
            rx_shift_r <= 9'h000;
            rx_par_r <= odd_parity;
            rx_perr_r <= 1'b0;
            rx_st_r <= SER_START;
          end
        end
        SER_START: begin
          if (rx_sample) rx_st_r <= serial_rx_in ? SER_IDLE : SER_DATA;
        end
        SER_DATA: begin
          if (rx_sample) begin
            rx_shift_r[rx_idx_r] <= serial_rx_in;
            rx_par_r <= rx_par_r ^ serial_rx_in;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == last_idx)
              rx_st_r <= has_parity ? SER_PARITY : SER_STOP;
          end
        end
        SER_PARITY: begin
          if (rx_sample) begin
            rx_perr_r <= rx_par_r ^ serial_rx_in;
            rx_st_r <= SER_STOP;
          end
        end
        SER_STOP: begin
          if (rx_sample) rx_st_r <= SER_IDLE;
        end
        default: rx_st_r <= SER_IDLE;
      endcase
    end
  end

  // pulse on a matching address char
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) match_r <= 1'b0;
    else match_r <= rx_done & adet_on & hit;
  end

endmodule
`default_nettype wire

/* File: sim/uda_port_asserts.sv */
// concurrent checks on the serial port register block ports
// assumes a bind to uda_port; sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module uda_port_asserts
  import uda_pkg::*;
#(
  parameter int RX_DEPTH = 4 // receive buffer entries
)(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic serial_rx_in, // serial in
  input wire logic serial_tx_out, // serial out
  input wire logic addr_match_pulse // match pulse
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  wire logic req = avs_read | avs_write; // any request
  wire logic acc = req & ~avs_waitrequest; // accept cycle
  wire logic rd_acc = avs_read & acc; // read taken
  wire logic wr_acc = avs_write & acc; // write taken
  wire logic [15:0] lanes = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [15:0] wd = avs_writedata[15:0]; // used half of write data
  logic [15:0] baud_r, admd_r; // expected register contents
  // shadows follow accepted writes lane by lane
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      baud_r <= RST_BAUD;
      admd_r <= RST_ADMD;
    end else if (wr_acc && avs_address == OFS_BAUD) begin
      baud_r <= (baud_r & ~lanes) | (wd & lanes);
    end else if (wr_acc && avs_address == OFS_ADMD) begin
      admd_r <= (admd_r & ~lanes) | (wd & lanes);
    end
  end
  a_wait_one_late: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait not one cycle");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_wait_needs_req: assert property ($fell(avs_waitrequest) |-> $past(req))
    else $error("wait low with no request");
  a_rx_upper_zero: assert property (
    rd_acc && avs_address == OFS_RX_DATA |-> avs_readdata[31:9] == '0)
    else $error("rx upper bits set");
  a_tx_reads_zero: assert property (
    rd_acc && avs_address == OFS_TX_DATA |-> avs_readdata == '0)
    else $error("tx reads nonzero");
  a_baud_readback: assert property (
    rd_acc && avs_address == OFS_BAUD |-> avs_readdata == {16'h0000, baud_r})
    else $error("baud readback");
  a_admd_readback: assert property (
    rd_acc && avs_address == OFS_ADMD |-> avs_readdata == {16'h0000, admd_r})
    else $error("admd readback");
  a_match_one_cycle: assert property (
    addr_match_pulse |=> !addr_match_pulse)
    else $error("match pulse too long");
  a_unmapped_zero: assert property (
    rd_acc && (avs_address > OFS_STAT || avs_address[1:0] != 2'h0)
    |-> avs_readdata == '0)
    else $error("unmapped nonzero");
endmodule
`default_nettype wire

/* File: sim/uda_serial_node.sv */
// remote serial node: sends frames to the port and checks its frames
// assumes an idle-high line, one stop bit, tasks called by the bench
`timescale 1ns/1ps
`default_nettype none
module uda_serial_node
  import uda_pkg::*;
(
  input wire logic clk_sys, // bench clock, paces the bits
  output logic line_out, // to the port's serial input
  input wire logic line_in // from the port's serial output
);
  initial line_out = 1'b1; // idle high between frames
  // parity bit of the 8-bit formats
  function automatic logic par_of(input logic [8:0] ch, input logic [1:0] fmt);
    par_of = (fmt == FMT_8_ODD) ? ~^ch[7:0] : ^ch[7:0];
  endfunction
  // drive one frame lsb first, each bit bclk clocks
  task automatic send_char(input logic [8:0] ch, input int bclk,
      input logic [1:0] fmt);
    logic [11:0] fr;
    int n;
    fr = '1;
    fr[0] = 1'b0;
    n = (fmt == FMT_9_NONE) ? 9 : 8;
    for (int i = 0; i < n; i++)
      fr[i + 1] = ch[i];
    n = n + 1;
    if (fmt == FMT_8_EVEN || fmt == FMT_8_ODD) begin
      fr[n] = par_of(ch, fmt);
      n = n + 1;
    end
    for (int i = 0; i <= n; i++) begin
      line_out <= fr[i];
      repeat (bclk) @(posedge clk_sys);
    end
  endtask
  // sample a port frame mid-bit; ok low on any framing fault
  task automatic recv_char(output logic [8:0] ch, output logic ok,
      input int bclk, input logic [1:0] fmt);
    int n;
    n = (fmt == FMT_9_NONE) ? 9 : 8;
    ch = '0;
    @(negedge line_in);
    repeat (bclk / 2) @(posedge clk_sys);
    ok = (line_in === 1'b0);
    for (int i = 0; i < n; i++) begin
      repeat (bclk) @(posedge clk_sys);
      ch[i] = line_in;
    end
    if (fmt == FMT_8_EVEN || fmt == FMT_8_ODD) begin
      repeat (bclk) @(posedge clk_sys);
      ok = ok && (line_in === par_of(ch, fmt));
    end
    repeat (bclk) @(posedge clk_sys);
    ok = ok && (line_in === 1'b1);
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_uda_port.sv */
// self-checking bench for the serial port register block
// assumes uda_port, its checker and the serial node model
`timescale 1ns/1ps
`default_nettype none
module tb_uda_port;
  import uda_pkg::*;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, d;
  logic [3:0] avs_byteenable, be;
  logic rx_line, tx_line, addr_match_pulse, ok, hs;
  logic [8:0] ch, got;
  logic [8:0] tbl [4] = '{9'h1a5, 9'h1aa, 9'h1b5, 9'h0a5};
  logic [15:0] baud_m = '0, admd_m = '0;
  logic [1:0] fmt;
  int div, bc, p0, pulses = 0, cycles = 0, miscompares = 0, total_checks = 0;
  uda_port #(.RX_DEPTH(4)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_rx_in(rx_line), .serial_tx_out(tx_line),
    .addr_match_pulse(addr_match_pulse)
  );
  uda_serial_node node (
    .clk_sys(clk_sys), .line_out(rx_line), .line_in(tx_line)
  );
  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // count match pulses, cut a hang short
  always @(posedge clk_sys) begin
    pulses <= pulses + (addr_match_pulse === 1'b1 ? 1 : 0);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus cycle: hold until waitrequest sampled low at a rising edge
  task automatic xfer(input logic wr_en, input logic [4:0] a,
      input logic [31:0] wdat, input logic [3:0] lanes, output logic [31:0] r);
    avs_address <= a;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    avs_writedata <= wdat;
    avs_byteenable <= lanes;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] wdat);
    logic [31:0] r;
    xfer(1'b1, a, wdat, 4'hf, r);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0000_0000, 4'hf, r);
  endtask
  // expected contents after a lane-masked write
  function automatic logic [15:0] merge(input logic [15:0] old, nw,
      input logic [3:0] lanes);
    merge = {lanes[1] ? nw[15:8] : old[15:8], lanes[0] ? nw[7:0] : old[7:0]};
  endfunction
  function automatic logic [31:0] ctrl(input logic h, input logic [1:0] f,
      input logic det);
    ctrl = '0;
    ctrl[CTRL_ENABLE_BIT] = 1'b1;
    ctrl[CTRL_HIGH_SPEED_BIT] = h;
    ctrl[CTRL_FMT_LSB +: 2] = f;
    ctrl[CTRL_ADDR_DET_BIT] = det;
  endfunction
  function automatic int bit_clks(input logic h, input int dv);
    bit_clks = (h ? 4 : 16) * (dv + 1);
  endfunction
  // pop receive data, compare with expected character
  task automatic pop_rx(input string what, input logic [8:0] e);
    logic [31:0] r;
    rd(OFS_RX_DATA, r);
    check(what, r, 32'(e));
  endtask
  task automatic rx_empty();
    logic [31:0] r;
    rd(OFS_STAT, r);
    check("rx avail", 32'(r[STAT_RXDA_BIT]), 32'h0000_0000);
  endtask
  initial begin
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
    d = $urandom(32'h5ea8_2938);
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // reset values, read-only and write-only places
    rd(OFS_BAUD, q);
    check("baud reset", q, 32'h0000_0000);
    rd(OFS_ADMD, q);
    check("admd reset", q, 32'h0000_0000);
    wr(OFS_RX_DATA, 32'h0000_01ff);
    pop_rx("rx reset", 9'h000);
    rd(OFS_TX_DATA, q);
    check("tx read", q, 32'h0000_0000);
    rd(5'h1a, q);
    check("unmapped", q, 32'h0000_0000);
    $display("test reset done");
    // random lane-masked writes and read-back
    for (int i = 0; i < 6; i++) begin
      d = $urandom();
      be = 4'($urandom());
      xfer(1'b1, OFS_BAUD, d, be, q);
      baud_m = merge(baud_m, d[15:0], be);
      xfer(1'b1, OFS_ADMD, ~d, be, q);
      admd_m = merge(admd_m, ~d[15:0], be);
      rd(OFS_BAUD, q);
      check("baud rw", q, {16'h0000, baud_m});
      rd(OFS_ADMD, q);
      check("admd rw", q, {16'h0000, admd_m});
    end
    $display("test registers done");
    // transmit in every format, both speeds, random divisor
    for (int k = 0; k < 4; k++) begin
      fmt = 2'(k);
      hs = k[0];
      div = $urandom_range(3);
      bc = bit_clks(hs, div);
      ch = 9'($urandom());
      wr(OFS_BAUD, 32'(div));
      wr(OFS_CTRL, ctrl(hs, fmt, 1'b0));
      fork
        node.recv_char(got, ok, bc, fmt);
        wr(OFS_TX_DATA, 32'(ch));
      join
      d = (fmt == FMT_9_NONE) ? 32'(ch) : 32'(ch[7:0]);
      check("tx char", 32'(got), d);
      check("tx frame", 32'(ok), 32'h0000_0001);
      repeat (bc) @(posedge clk_sys);
    end
    $display("test transmit done");
    // two characters received back to back, popped in order
    wr(OFS_BAUD, 32'h0000_0001);
    wr(OFS_CTRL, ctrl(1'b1, FMT_9_NONE, 1'b0));
    ch = 9'($urandom());
    got = 9'($urandom());
    node.send_char(ch, 8, FMT_9_NONE);
    node.send_char(got, 8, FMT_9_NONE);
    rd(OFS_STAT, q);
    check("rx avail", 32'(q[STAT_RXDA_BIT]), 32'h0000_0001);
    pop_rx("rx first", ch);
    pop_rx("rx second", got);
    rx_empty();
    // address detect: masked match, data chars dropped
    wr(OFS_ADMD, 32'h0000_f0a5);
    wr(OFS_CTRL, ctrl(1'b1, FMT_9_NONE, 1'b1));
    p0 = pulses;
    foreach (tbl[i])
      node.send_char(tbl[i], 8, FMT_9_NONE);
    check("match pulses", 32'(pulses - p0), 32'h0000_0002);
    pop_rx("rx match", 9'h1a5);
    pop_rx("rx masked", 9'h1aa);
    rx_empty();
    // detect has no effect in 8-bit format
    wr(OFS_CTRL, ctrl(1'b1, FMT_8_NONE, 1'b1));
    node.send_char(9'h03c, 8, FMT_8_NONE);
    pop_rx("rx 8bit", 9'h03c);
    $display("test receive done");
    final_report();
  end
endmodule
bind uda_port uda_port_asserts #(.RX_DEPTH(RX_DEPTH)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
  .addr_match_pulse(addr_match_pulse)
);
`default_nettype wire
